// file: sim/bbseq_afe.sv
// analog front end model: flying capacitor and boost reservoir
`timescale 1ns/1ps
module bbseq_afe (
  // clock
  input wire logic mclk,
  // pump switches
  input wire logic pump_charge_switch,
  input wire logic pump_transfer_switch,
  // level flags
  output logic flyAboveHi,
  output logic flyBelowLo,
  output logic boostStartOk,
  output logic boostAboveHi,
  output logic boostBelowLo
);
  // fly in 100 mV steps, boost in 10 mV steps; boost leaks when idle
  int fly = 0;
  int boost = 0;
  always @(posedge mclk) begin
    if (pump_charge_switch) fly <= fly + 1;
    if (pump_transfer_switch && fly > 0) fly <= fly - 1;
    if (pump_transfer_switch && fly >= 95) boost <= boost + 6;
    else if (boost > 0) boost <= boost - 1;
  end
  // plain levels; the sequencer resynchronises them
  assign flyAboveHi = fly >= 105;
  assign flyBelowLo = fly <= 95;
  assign boostStartOk = boost >= 695;
  assign boostAboveHi = boost >= 845;
  assign boostBelowLo = boost <= 825;
endmodule

// file: sim/bbseq_props.sv
// port assertions for the balance sequencer
`timescale 1ns/1ps
module bbseq_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // pins and flags
  input wire logic modeSel,
  input wire logic stack_select_lo,
  input wire logic stack_select_hi,
  input wire logic termWithin,
  input wire logic flyAboveHi,
  input wire logic boostStartOk,
  input wire logic boostAboveHi,
  input wire logic uvDetect,
  input wire logic ovDetect,
  input wire logic regUnderVolt,
  input wire logic overTemp,
  // drives and status
  input wire logic [3:0] bottomGate,
  input wire logic [3:0] topGate,
  input wire logic pump_charge_switch,
  input wire logic pump_transfer_switch,
  input wire logic balActiveOe,
  input wire logic stackBalOe,
  input wire logic uvFaultOe,
  input wire logic ovFaultOe,
  input wire logic [1:0] batIndex
);
  logic en;
  logic act;
  assign en = stack_select_lo || stack_select_hi;
  assign act = en && !regUnderVolt && !overTemp;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------
  // windows allow two sync flops plus the register
  // ---------------------------------------------
  chk_shut_off: assert property (
    (!en)[*4] |-> bottomGate == 4'h0 && topGate == 4'h0
      && !pump_charge_switch && !balActiveOe && !stackBalOe)
    else $error("drive on in shutdown");
  chk_cont_active: assert property (
    (modeSel && act)[*5] |-> balActiveOe)
    else $error("active flag released");
  chk_uv_set: assert property (
    (uvDetect && act)[*4] |-> uvFaultOe)
    else $error("uv fault missing");
  chk_uv_clear: assert property (
    (!uvDetect)[*4] |-> !uvFaultOe)
    else $error("uv fault stuck");
  chk_ov_set: assert property (
    (ovDetect && act)[*4] |-> ovFaultOe)
    else $error("ov fault missing");
  chk_pump_flip: assert property (
    (flyAboveHi && en && !regUnderVolt)[*5] |-> !pump_charge_switch)
    else $error("charge past upper level");
  chk_pump_hold: assert property (
    (boostAboveHi && en && !regUnderVolt)[*5]
      |-> pump_transfer_switch && !pump_charge_switch)
    else $error("pump cycling when full");
  chk_start_gate: assert property (
    bottomGate != 4'h0 && $past(bottomGate) == 4'h0 && batIndex == 2'h0
      |-> $past(boostStartOk, 3))
    else $error("start below level");
  chk_timer_no_top: assert property (
    $rose(|topGate) |-> $past(modeSel, 3) || !$past(termWithin, 3)
      || !$past(termWithin, 4))
    else $error("top closed on balanced battery");
  chk_break_gap: assert property (
    $fell(|bottomGate) |-> (bottomGate == 4'h0)[*3])
    else $error("bottom switches closed without a gap");
  cover property (stackBalOe && balActiveOe);
  cover property ($rose(|topGate));
  cover property ($fell(pump_transfer_switch));
endmodule

bind bbseq_top bbseq_props u_bbseq_props (.*);

// file: sim/bbseq_top_bench.sv
// self-checking bench for the balance sequencer
`timescale 1ns/1ps
`define CMP(nm, e, a) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      fail_count++; \
      $display("wrong value %s exp %h got %h", nm, e, a); \
    end \
  end
module bbseq_top_bench;
  typedef struct {
    int k;
    logic [11:0] m;
    logic [11:0] v;
  } bbseq_note_t;
  logic mclk, rst_b, clkEn, modeSel, stack_select_lo, stack_select_hi;
  logic tonEnable, termWithin, uvDetect, ovDetect, regUnderVolt, overTemp;
  logic flyAboveHi, flyBelowLo, boostStartOk, boostAboveHi, boostBelowLo;
  logic [3:0] bottomGate, topGate, rises;
  logic [1:0] batIndex;
  logic pump_charge_switch, pump_transfer_switch, balance_active_n;
  logic balActiveOe, stack_balanced_flag, stackBalOe, undervolt_fault_n;
  logic uvFaultOe, overvolt_fault_n, ovFaultOe, chkReq, clrCnt, botQ;
  logic [11:0] stat;
  logic [3:0] pinLv;
  logic [31:0] rnd;
  int fail_count = 0;
  int n_compared = 0;
  bbseq_note_t noteQ[$];
  bbseq_note_t nt;
  // short counts keep the run brief
  bbseq_top #(.SETTLE_CYC(8), .BBM_CYC(8), .TBAT_CYC(40), .TON_CYC(400),
    .TOFF_CYC(40)) u_bbseq_top (.*);
  bbseq_afe u_bbseq_afe (.*);
  assign stat = {batIndex, rises, |bottomGate, |topGate, balActiveOe,
    stackBalOe, uvFaultOe, ovFaultOe};
  // open-drain value pins only ever pull low
  assign pinLv = {balance_active_n, stack_balanced_flag, undervolt_fault_n,
    overvolt_fault_n};
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // -----------------------------------------
  // monitor: bottom connections and note checks
  // -----------------------------------------
  always @(posedge mclk) begin
    botQ <= |bottomGate;
    if (clrCnt) rises <= 4'h0;
    else if (|bottomGate && !botQ) rises <= rises + 4'h1;
    if (chkReq) begin
      nt = noteQ.pop_front();
      case (nt.k)
        0: `CMP("shutdown", nt.v, stat & nt.m)
        1: `CMP("balanced", nt.v, stat & nt.m)
        2: `CMP("continuous", nt.v, stat & nt.m)
        3: `CMP("faults", nt.v, stat & nt.m)
        4: `CMP("regulator", nt.v, stat & nt.m)
        default: `CMP("thermal", nt.v, stat & nt.m)
      endcase
      `CMP("open-drain levels", 4'h0, pinLv)
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // the spare edge keeps two notes from touching chkReq at once
  task automatic note(input int k, input logic [11:0] m,
    input logic [11:0] v);
    noteQ.push_back('{k, m, v});
    chkReq <= 1'b1;
    @(posedge mclk);
    chkReq <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_st(input logic [11:0] m, input logic [11:0] v);
    for (int i = 0; i < 4000 && (stat & m) !== v; i++) @(posedge mclk);
    `CMP("wait", v, stat & m)
  endtask
  task automatic shut_then(input logic [1:0] s);
    {stack_select_lo, stack_select_hi} <= 2'b00;
    clrCnt <= 1'b1;
    cyc(6);
    note(0, 12'h03F, 12'h000);
    {stack_select_lo, stack_select_hi} <= s;
    clrCnt <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst_b, clkEn, modeSel, tonEnable} = 4'h4;
    {stack_select_lo, stack_select_hi} = 2'b00;
    {termWithin, uvDetect, ovDetect, regUnderVolt, overTemp} = 5'h10;
    {chkReq, clrCnt, rnd} = {2'b01, 32'h0000_7CB6};
    cyc(12);
    rst_b <= 1'b1;
    // timer mode: two, three and four batteries
    for (int i = 1; i < 4; i++) begin
      shut_then(i[1:0]);
      wait_st(12'h004, 12'h004);
      note(1, 12'h3D4, {2'h0, 4'(i + 2), 6'h04});
      $display("test timer stack %0d done", i + 1);
    end
    modeSel <= 1'b1;
    shut_then(2'b01);
    wait_st(12'h010, 12'h010);
    note(2, 12'h018, 12'h018);
    wait_st(12'h004, 12'h004);
    note(2, 12'h00C, 12'h00C);
    clrCnt <= 1'b1;
    cyc(1);
    clrCnt <= 1'b0;
    wait_st(12'h3C0, 12'h080);
    note(2, 12'h3C8, 12'h088);
    $display("test continuous done");
    repeat (6) begin
      rnd = xs(rnd);
      uvDetect <= rnd[0];
      ovDetect <= rnd[1];
      cyc(5);
      note(3, 12'h00B, {8'h0, 2'b10, rnd[0], rnd[1]});
    end
    {uvDetect, ovDetect} <= 2'b00;
    $display("test faults done");
    for (int j = 0; j < 2; j++) begin
      {regUnderVolt, overTemp} <= j == 0 ? 2'b10 : 2'b01;
      cyc(6);
      note(4 + j, 12'hC30, 12'h000);
      {regUnderVolt, overTemp} <= 2'b00;
      wait_st(12'h020, 12'h020);
      note(4 + j, 12'hC20, 12'h020);
      $display("test abort %0d done", j);
    end
    tally_and_finish();
  end
endmodule

// file: verilog/bbseq_cfg.svh
// timing constants and field widths for the balance sequencer
`ifndef BBSEQ_CFG_SVH
`define BBSEQ_CFG_SVH

`define BBSEQ_CLK_MHZ 200
`define BBSEQ_SETTLE_MS 35
`define BBSEQ_BBM_MS 40
`define BBSEQ_SETTLE_CYC (`BBSEQ_SETTLE_MS * 1000 * `BBSEQ_CLK_MHZ)
`define BBSEQ_BBM_CYC (`BBSEQ_BBM_MS * 1000 * `BBSEQ_CLK_MHZ)
`define BBSEQ_TBAT_CYC 1000000000
`define BBSEQ_TON_CYC 1000000000
`define BBSEQ_TOFF_CYC 1000000000
`define BBSEQ_CNT_W 32
`define BBSEQ_BAT_W 2
`define BBSEQ_BAL2 3'h3
`define BBSEQ_BAL3 3'h4
`define BBSEQ_BAL4 3'h5
`define BBSEQ_NBAT2 2'h1
`define BBSEQ_NBAT3 2'h2
`define BBSEQ_NBAT4 2'h3

`endif

// file: verilog/bbseq_pkg.sv
// types shared by the balance sequencer
package bbseq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_BOTTOM, SEQ_TOP, SEQ_BBM, SEQ_OFF
  } bbseq_state_t;
  typedef enum logic {PUMP_CHARGE, PUMP_TRANSFER} bbseq_pump_t;
endpackage

// file: verilog/bbseq_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bbseq_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // level
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end
endmodule

// file: verilog/bbseq_top.sv
// balance sequencer: switch sequencing, charge pump and faults
//
// Operation
// - continuous mode never enters timed on or low-power off states
// - continuous mode keeps cycling after balanced until shutdown
// - balance_active_n held low throughout continuous mode
// - timer mode: balanced on bottom switches ends battery, no top
// - continuous mode: top switches always on, end only on timeout
// - continuous mode still asserts stack_balanced_flag low when balanced
// - pump charges flying capacitor to upper level, transfers to lower
// - balancing waits for boost reservoir start threshold flag
// - pump stops with transfer closed at upper level, resumes at lower
// - fault outputs pulled low on fault; balancing continues
// - fault outputs released when the fault disappears
// - regulator undervoltage aborts; restart from beginning on clear
// - over-temperature halts balancing until flag releases
// - stack selects choose two, three or four battery sequencing
// - two batteries: balanced after three bottom-only in-threshold cycles
// - three batteries: balanced after four such cycles
// - both selects low: shutdown, drives off, status released
// - mode high continuous, low timer
// - per-battery timeout restarts on each new battery
// - break-before-make delay before next bottom switches
`timescale 1ns/1ps
`include "bbseq_cfg.svh"
module bbseq_top
  import bbseq_pkg::*;
#(
  parameter int SETTLE_CYC = `BBSEQ_SETTLE_CYC,
  parameter int BBM_CYC = `BBSEQ_BBM_CYC,
  parameter int TBAT_CYC = `BBSEQ_TBAT_CYC,
  parameter int TON_CYC = `BBSEQ_TON_CYC,
  parameter int TOFF_CYC = `BBSEQ_TOFF_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // configuration pins
  input wire logic modeSel,
  input wire logic stack_select_lo,
  input wire logic stack_select_hi,
  input wire logic tonEnable,
  // analog comparator flags
  input wire logic termWithin,
  input wire logic flyAboveHi,
  input wire logic flyBelowLo,
  input wire logic boostStartOk,
  input wire logic boostAboveHi,
  input wire logic boostBelowLo,
  input wire logic uvDetect,
  input wire logic ovDetect,
  input wire logic regUnderVolt,
  input wire logic overTemp,
  // switch drives
  output logic [3:0] bottomGate,
  output logic [3:0] topGate,
  output logic pump_charge_switch,
  output logic pump_transfer_switch,
  // open-drain status: oe high pulls low
  output logic balance_active_n,
  output logic balActiveOe,
  output logic stack_balanced_flag,
  output logic stackBalOe,
  output logic undervolt_fault_n,
  output logic uvFaultOe,
  output logic overvolt_fault_n,
  output logic ovFaultOe,
  output logic [1:0] batIndex
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syn;
  assign rawIn = {modeSel, stack_select_lo, stack_select_hi, tonEnable,
                  termWithin, flyAboveHi, flyBelowLo, boostStartOk,
                  boostAboveHi, boostBelowLo, uvDetect, ovDetect,
                  regUnderVolt, overTemp};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      bbseq_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(rawIn[gi]),
        .syncOut(syn[gi])
      );
    end
  endgenerate

  logic sMode, sSelLo, sSelHi, sTon, sTerm, sFlyHi, sFlyLo, sStart;
  logic sBoostHi, sBoostLo, sUv, sOv, sRegUv, sOt;
  assign {sMode, sSelLo, sSelHi, sTon, sTerm, sFlyHi, sFlyLo, sStart,
          sBoostHi, sBoostLo, sUv, sOv, sRegUv, sOt} = syn;

  // ----------------------------------------------------------------
  // enable decode
  // ----------------------------------------------------------------
  logic shutdown, halted, contMode;
  logic [1:0] lastBat;
  logic [2:0] balNeed;
  assign shutdown = !sSelLo && !sSelHi;
  // regulator undervolt and thermal stop both force a fresh start
  assign halted = shutdown || sRegUv || sOt;
  assign contMode = sMode;

  always_comb begin
    unique case ({sSelLo, sSelHi})
      2'b01: begin
        lastBat = `BBSEQ_NBAT2;
        balNeed = `BBSEQ_BAL2;
      end
      2'b10: begin
        lastBat = `BBSEQ_NBAT3;
        balNeed = `BBSEQ_BAL3;
      end
      default: begin
        lastBat = `BBSEQ_NBAT4;
        balNeed = `BBSEQ_BAL4;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // balancing sequencer
  // ----------------------------------------------------------------
  bbseq_state_t state_ff;
  logic [`BBSEQ_CNT_W-1:0] phaseCnt_ff;
  logic [`BBSEQ_CNT_W-1:0] tbatCnt_ff;
  logic [`BBSEQ_CNT_W-1:0] tonCnt_ff;
  logic [1:0] bat_ff;
  logic [2:0] goodRun_ff;
  logic balanced_ff;
  logic settled, tbatDone, tonDone, bbmDone, offDone, stackDone;
  logic lastOfRun;

  assign settled = phaseCnt_ff >= `BBSEQ_CNT_W'(SETTLE_CYC - 1);
  assign bbmDone = phaseCnt_ff >= `BBSEQ_CNT_W'(BBM_CYC - 1);
  assign offDone = phaseCnt_ff >= `BBSEQ_CNT_W'(TOFF_CYC - 1);
  assign tbatDone = tbatCnt_ff >= `BBSEQ_CNT_W'(TBAT_CYC - 1);
  assign tonDone = sTon && (tonCnt_ff >= `BBSEQ_CNT_W'(TON_CYC - 1));
  assign lastOfRun = (goodRun_ff + 3'h1) >= balNeed;
  assign stackDone = balanced_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SEQ_IDLE;
      phaseCnt_ff <= '0;
      bat_ff <= '0;
    end else if (clkEn) begin
      phaseCnt_ff <= phaseCnt_ff + `BBSEQ_CNT_W'(1);
      if (halted) begin
        state_ff <= SEQ_IDLE;
        phaseCnt_ff <= '0;
        bat_ff <= '0;
      end else begin
        unique case (state_ff)
          SEQ_IDLE: begin
            phaseCnt_ff <= '0;
            if (sStart) begin
              state_ff <= SEQ_BOTTOM;
            end
          end
          SEQ_BOTTOM: begin
            if (settled) begin
              phaseCnt_ff <= '0;
              if (sTerm && !contMode) begin
                state_ff <= SEQ_BBM;
              end else begin
                state_ff <= SEQ_TOP;
              end
            end
          end
          SEQ_TOP: begin
            // continuous mode ignores the comparator in top; only tbatDone ends it
            if (tbatDone || (!contMode && settled && sTerm)) begin
              state_ff <= SEQ_BBM;
              phaseCnt_ff <= '0;
            end
          end
          SEQ_BBM: begin
            if (bbmDone) begin
              phaseCnt_ff <= '0;
              bat_ff <= (bat_ff == lastBat) ? 2'h0 : bat_ff + 2'h1;
              // timer mode rests when balanced or on-time ran out
              if (!contMode && (balanced_ff || tonDone)) begin
                state_ff <= SEQ_OFF;
              end else begin
                state_ff <= SEQ_BOTTOM;
              end
            end
          end
          SEQ_OFF: begin
            if (contMode || offDone) begin
              state_ff <= SEQ_IDLE;
              phaseCnt_ff <= '0;
              bat_ff <= '0;
            end
          end
        endcase
      end
    end
  end

  // per-battery timeout, restarted on each new battery
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tbatCnt_ff <= '0;
    end else if (clkEn) begin
      if (state_ff == SEQ_BOTTOM || state_ff == SEQ_TOP) begin
        if (!tbatDone) begin
          tbatCnt_ff <= tbatCnt_ff + `BBSEQ_CNT_W'(1);
        end
      end else begin
        tbatCnt_ff <= '0;
      end
    end
  end

  // on-time limit for timer mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tonCnt_ff <= '0;
    end else if (clkEn) begin
      if (state_ff == SEQ_IDLE || state_ff == SEQ_OFF) begin
        tonCnt_ff <= '0;
      end else if (!tonDone) begin
        tonCnt_ff <= tonCnt_ff + `BBSEQ_CNT_W'(1);
      end
    end
  end

  // run of bottom-only in-threshold results decides stack balance
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      goodRun_ff <= '0;
      balanced_ff <= 1'b0;
    end else if (clkEn) begin
      if (halted || state_ff == SEQ_OFF) begin
        goodRun_ff <= '0;
        balanced_ff <= 1'b0;
      end else if (state_ff == SEQ_BOTTOM && settled) begin
        if (sTerm) begin
          if (lastOfRun) begin
            balanced_ff <= 1'b1;
          end else begin
            goodRun_ff <= goodRun_ff + 3'h1;
          end
        end else begin
          goodRun_ff <= '0;
          balanced_ff <= contMode && balanced_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // charge pump phase control
  // ----------------------------------------------------------------
  bbseq_pump_t pump_ff;
  logic pumpHold_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pump_ff <= PUMP_CHARGE;
      pumpHold_ff <= 1'b0;
    end else if (clkEn) begin
      if (shutdown || sRegUv) begin
        pump_ff <= PUMP_CHARGE;
        pumpHold_ff <= 1'b0;
      end else begin
        if (sBoostHi) begin
          pumpHold_ff <= 1'b1;
        end else if (sBoostLo) begin
          pumpHold_ff <= 1'b0;
        end
        if (pumpHold_ff || sBoostHi) begin
          pump_ff <= PUMP_TRANSFER;
        end else begin
          unique case (pump_ff)
            PUMP_CHARGE: if (sFlyHi) pump_ff <= PUMP_TRANSFER;
            PUMP_TRANSFER: if (sFlyLo) pump_ff <= PUMP_CHARGE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic pumpOn;
  assign pumpOn = !(shutdown || sRegUv);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bottomGate <= '0;
      topGate <= '0;
      pump_charge_switch <= 1'b0;
      pump_transfer_switch <= 1'b0;
      batIndex <= '0;
    end else if (clkEn) begin
      bottomGate <= '0;
      topGate <= '0;
      if (!halted && (state_ff == SEQ_BOTTOM || state_ff == SEQ_TOP)) begin
        bottomGate[bat_ff] <= 1'b1;
        topGate[bat_ff] <= (state_ff == SEQ_TOP);
      end
      pump_charge_switch <= pumpOn && (pump_ff == PUMP_CHARGE);
      pump_transfer_switch <= pumpOn && (pump_ff == PUMP_TRANSFER);
      batIndex <= bat_ff;
    end
  end

  // status pins: value stays low, enable pulls the wire
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      balance_active_n <= 1'b0;
      balActiveOe <= 1'b0;
      stack_balanced_flag <= 1'b0;
      stackBalOe <= 1'b0;
      undervolt_fault_n <= 1'b0;
      uvFaultOe <= 1'b0;
      overvolt_fault_n <= 1'b0;
      ovFaultOe <= 1'b0;
    end else if (clkEn) begin
      balActiveOe <= !shutdown &&
        (contMode || (!halted && state_ff != SEQ_IDLE &&
         state_ff != SEQ_OFF));
      stackBalOe <= !halted && stackDone;
      uvFaultOe <= !shutdown && sUv;
      ovFaultOe <= !shutdown && sOv;
    end
  end

endmodule
